// ### core/tcc_pkg.sv
// Purpose: Constants shared by the 8-bit timer/counter core
// Assumes: 8-bit register port, one system clock
// Notes:   Offsets are register indices on the plain port
package tcc_pkg;
    localparam int          TCC_DW          = 8;
    localparam int          TCC_AW          = 3;
    localparam int          TCC_PRE_W       = 10;
    // Register indices
    localparam logic [2:0]  TCC_OFS_CTRL_A  = 3'h0;
    localparam logic [2:0]  TCC_OFS_CTRL_B  = 3'h1;
    localparam logic [2:0]  TCC_OFS_COUNT   = 3'h2;
    localparam logic [2:0]  TCC_OFS_CMP_A   = 3'h3;
    localparam logic [2:0]  TCC_OFS_CMP_B   = 3'h4;
    localparam logic [2:0]  TCC_OFS_FLAG    = 3'h5;
    localparam logic [2:0]  TCC_OFS_MASK    = 3'h6;
    localparam logic [2:0]  TCC_OFS_ASYNC   = 3'h7;
    // Field positions
    localparam int          TCC_WGM0_BIT    = 0;
    localparam int          TCC_WGM1_BIT    = 1;
    localparam int          TCC_WGM2_BIT    = 3;
    localparam int          TCC_CS_LSB      = 0;
    localparam int          TCC_OVF_BIT     = 0;
    localparam int          TCC_CMPA_BIT    = 1;
    localparam int          TCC_CMPB_BIT    = 2;
    localparam int          TCC_AS_BIT      = 5;
    // Values
    localparam logic [7:0]  TCC_BOTTOM      = 8'h00;
    localparam logic [7:0]  TCC_MAX         = 8'hFF;
    localparam logic [7:0]  TCC_RST8        = 8'h00;
    localparam logic [2:0]  TCC_CS_STOP     = 3'h0;
    localparam logic [2:0]  TCC_WGM_NORMAL  = 3'h0;
    localparam logic [2:0]  TCC_WGM_PC_MAX  = 3'h1;
    localparam logic [2:0]  TCC_WGM_CTC     = 3'h2;
    localparam logic [2:0]  TCC_WGM_FP_MAX  = 3'h3;
    localparam logic [2:0]  TCC_WGM_PC_OCRA = 3'h5;
    localparam logic [2:0]  TCC_WGM_FP_OCRA = 3'h7;
    // Prescaler tap masks, divisor minus one
    localparam logic [9:0]  TCC_DIV1        = 10'h000;
    localparam logic [9:0]  TCC_DIV8        = 10'h007;
    localparam logic [9:0]  TCC_DIV32       = 10'h01F;
    localparam logic [9:0]  TCC_DIV64       = 10'h03F;
    localparam logic [9:0]  TCC_DIV128      = 10'h07F;
    localparam logic [9:0]  TCC_DIV256      = 10'h0FF;
    localparam logic [9:0]  TCC_DIV1024     = 10'h3FF;
    localparam logic [9:0]  TCC_PRE_ONE     = 10'h001;
    localparam logic [7:0]  TCC_ONE8        = 8'h01;

    typedef enum logic {TCC_DIR_UP, TCC_DIR_DOWN} tcc_dir_t;
endpackage : tcc_pkg

// ### core/tcc_timer.sv
// Purpose: 8-bit timer/counter core with two compare channels
// Assumes: osc_pin_in is a slow crystal clock sampled by clk_in
// Notes:   Registers sit on a plain strobe port, read data one cycle late
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps

// Summary of operation
// RULE1: Count of zero is bottom; bottom indication raised there.
// RULE2: All ones is the maximum in every mode.
// RULE3: Top is the maximum or compare value A, by mode.
// RULE4: Count and both compare values are 8-bit software registers.
// RULE5: All requests sit in one flag register, each gated by a mask bit.
// RULE6: Clock select zero gives no ticks; counter halts.
// RULE7: Default tick source is the system clock via prescaler.
// RULE8: Async select bit takes ticks from the oscillator pin instead.
// RULE9: Both compare values are compared with the count at all times.
// RULE10: Equality sets that channel's compare flag, raising its request.
// RULE11: Each tick clears, increments or decrements per mode.
// RULE12: Steps are exactly one in the current direction; clear zeroes all bits.
// RULE13: Software reads and writes the count whether or not ticks run.
// RULE14: Software count write beats a same-cycle clear or count.
// RULE15: Three-bit mode: two bits in control A, one in control B.
// RULE16: Overflow flag set by mode condition, may raise a request.
// RULE17: Top and bottom indications are provided to waveform logic; top_out flags the all-ones maximum, not top.
// RULE18: Compare flag set on tick after equality; written one clears it.
// RULE19: A count write blocks compare matches for the next tick, even stopped.
// RULE20: Mode zero counts up, wraps to zero, sets overflow on reaching zero.
// RULE21: Mode two clears the count on match with compare A.
// RULE22: Oscillator ticks are synchronised safely into the register clock.
module tcc_timer
    import tcc_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              resetn_in,
    input  wire logic [TCC_AW-1:0] addr_in,
    input  wire logic [TCC_DW-1:0] wr_data_in,
    input  wire logic              wr_en_in,
    input  wire logic              rd_en_in,
    input  wire logic              osc_pin_in,
    output logic      [TCC_DW-1:0] rd_data_out,
    output logic                   osc_pin_out,
    output logic                   ovf_req_out,
    output logic                   cmp_a_req_out,
    output logic                   cmp_b_req_out,
    output logic                   top_out,
    output logic                   bottom_out
);
    // Reset release through two flops
    logic        rst_meta_reg;
    logic        rst_sync_reg;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire rstn = rst_sync_reg;

    logic [7:0]           control_register_a;
    logic [7:0]           control_register_b;
    logic [7:0]           timer_count_value;
    logic [7:0]           compare_value_a;
    logic [7:0]           compare_value_b;
    logic [7:0]           cmp_buf_a_reg;
    logic [7:0]           cmp_buf_b_reg;
    logic [2:0]           timer_flag_register;
    logic [2:0]           timer_mask_register;
    logic                 async_clock_select;
    logic [TCC_PRE_W-1:0] presc_reg;
    logic                 osc_meta_reg;
    logic                 osc_sync_reg;
    logic                 osc_last_reg;
    logic                 block_reg;
    tcc_dir_t             dir_reg;
    tcc_dir_t             dir_next;
    logic [7:0]           count_next;

    function automatic logic is_wr(input logic [2:0] a, input logic en, input logic [2:0] ofs);
        is_wr = en && (a == ofs);
    endfunction : is_wr

    function automatic logic [9:0] tap_mask(input logic [2:0] cs);
        case (cs)
            3'h1:    tap_mask = TCC_DIV1;
            3'h2:    tap_mask = TCC_DIV8;
            3'h3:    tap_mask = TCC_DIV32;
            3'h4:    tap_mask = TCC_DIV64;
            3'h5:    tap_mask = TCC_DIV128;
            3'h6:    tap_mask = TCC_DIV256;
            default: tap_mask = TCC_DIV1024;
        endcase
    endfunction : tap_mask

    // Register decode
    wire wr_ctrl_a = is_wr(addr_in, wr_en_in, TCC_OFS_CTRL_A);
    wire wr_ctrl_b = is_wr(addr_in, wr_en_in, TCC_OFS_CTRL_B);
    wire wr_count  = is_wr(addr_in, wr_en_in, TCC_OFS_COUNT);
    wire wr_cmp_a  = is_wr(addr_in, wr_en_in, TCC_OFS_CMP_A);
    wire wr_cmp_b  = is_wr(addr_in, wr_en_in, TCC_OFS_CMP_B);
    wire wr_flag   = is_wr(addr_in, wr_en_in, TCC_OFS_FLAG);
    wire wr_mask   = is_wr(addr_in, wr_en_in, TCC_OFS_MASK);
    wire wr_async  = is_wr(addr_in, wr_en_in, TCC_OFS_ASYNC);

    // Mode and source select
    wire       waveform_mode_bit0   = control_register_a[TCC_WGM0_BIT];
    wire       waveform_mode_bit1   = control_register_a[TCC_WGM1_BIT];
    wire       waveform_mode_bit2   = control_register_b[TCC_WGM2_BIT];
    // Third mode bit sits apart, in control B
    wire [2:0] waveform_mode_select = {waveform_mode_bit2, waveform_mode_bit1, waveform_mode_bit0}; // RULE15
    wire [2:0] clock_source_select  = control_register_b[TCC_CS_LSB +: 3];
    // Modes 4 and 6 fall back to normal counting
    wire       mode_pc   = (waveform_mode_select == TCC_WGM_PC_MAX) ||
                           (waveform_mode_select == TCC_WGM_PC_OCRA);
    wire       mode_fp   = (waveform_mode_select == TCC_WGM_FP_MAX) ||
                           (waveform_mode_select == TCC_WGM_FP_OCRA);
    wire       mode_ctc  = (waveform_mode_select == TCC_WGM_CTC);
    wire       mode_pwm  = mode_pc || mode_fp;
    wire       top_ocra  = (waveform_mode_select == TCC_WGM_PC_OCRA) ||
                           (waveform_mode_select == TCC_WGM_FP_OCRA);
    wire [7:0] top_value = top_ocra ? compare_value_a : TCC_MAX; // RULE3

    // Oscillator pin: plain two-flop synchroniser, edge seen on second copy
    wire osc_edge   = osc_sync_reg && !osc_last_reg; // RULE22
    // Prescaler advances on system clock or on oscillator edges
    wire presc_step = async_clock_select ? osc_edge : 1'b1; // RULE7 RULE8
    // Free-running, so the first tick after enabling comes at any phase
    wire [9:0] tap  = tap_mask(clock_source_select);
    wire timer_clock_tick = (clock_source_select != TCC_CS_STOP) && presc_step &&
                            ((presc_reg & tap) == tap); // RULE6

    // Status conditions
    wire at_bottom = (timer_count_value == TCC_BOTTOM); // RULE1
    wire at_max    = (timer_count_value == TCC_MAX); // RULE2
    wire at_top    = (timer_count_value == top_value);
    wire match_a   = (timer_count_value == compare_value_a); // RULE9
    wire match_b   = (timer_count_value == compare_value_b); // RULE9
    wire match_ok  = timer_clock_tick && !block_reg; // RULE19

    // Count sequence
    always_comb begin
        count_next = timer_count_value;
        dir_next   = dir_reg;
        if (mode_pc) begin
            case (dir_reg)
                TCC_DIR_UP: begin
                    if (at_top) begin
                        dir_next   = TCC_DIR_DOWN;
                        count_next = timer_count_value - TCC_ONE8; // RULE12
                    end else begin
                        count_next = timer_count_value + TCC_ONE8;
                    end
                end
                TCC_DIR_DOWN: begin
                    if (at_bottom) begin
                        dir_next   = TCC_DIR_UP;
                        count_next = timer_count_value + TCC_ONE8;
                    end else begin
                        count_next = timer_count_value - TCC_ONE8; // RULE12
                    end
                end
                default: begin
                    dir_next   = TCC_DIR_UP;
                    count_next = TCC_BOTTOM;
                end
            endcase
        end else if ((mode_ctc && match_a) || (mode_fp && at_top)) begin
            dir_next   = TCC_DIR_UP;
            count_next = TCC_BOTTOM; // RULE12 RULE21
        end else begin
            dir_next   = TCC_DIR_UP;
            count_next = timer_count_value + TCC_ONE8; // RULE20
        end
    end

    // Overflow condition per mode
    wire ovf_cond = mode_pc  ? (dir_reg == TCC_DIR_DOWN) && at_bottom :
                    mode_fp  ? at_top :
                    at_max; // RULE16 RULE20
    wire set_ovf  = timer_clock_tick && ovf_cond;
    // Matches use the pre-tick count, so a flag lands one tick late
    wire set_a    = match_ok && match_a; // RULE10 RULE18
    wire set_b    = match_ok && match_b; // RULE10 RULE18
    wire [2:0] flag_set = {set_b, set_a, set_ovf};
    wire [2:0] flag_clr = wr_flag ? wr_data_in[2:0] : 3'h0;
    // Buffer loads at top in PWM modes to avoid odd-length pulses
    wire buf_load = mode_pwm && timer_clock_tick && at_top;

    // Level requests, cleared through the flag register or dropped by the mask register
    wire [2:0] req_next = timer_flag_register & timer_mask_register; // RULE5

    // Read mux
    logic [7:0] rd_mux;
    always_comb begin
        case (addr_in)
            TCC_OFS_CTRL_A: rd_mux = control_register_a;
            TCC_OFS_CTRL_B: rd_mux = control_register_b;
            TCC_OFS_COUNT:  rd_mux = timer_count_value; // RULE13
            TCC_OFS_CMP_A:  rd_mux = mode_pwm ? cmp_buf_a_reg : compare_value_a;
            TCC_OFS_CMP_B:  rd_mux = mode_pwm ? cmp_buf_b_reg : compare_value_b;
            TCC_OFS_FLAG:   rd_mux = {5'h00, timer_flag_register};
            TCC_OFS_MASK:   rd_mux = {5'h00, timer_mask_register};
            TCC_OFS_ASYNC:  rd_mux = {2'h0, async_clock_select, 5'h00};
            default:        rd_mux = TCC_RST8;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_last_reg <= 1'b0;
            presc_reg    <= '0;
        end else begin
            osc_meta_reg <= osc_pin_in; // RULE22
            osc_sync_reg <= osc_meta_reg;
            osc_last_reg <= osc_sync_reg;
            presc_reg    <= presc_step ? presc_reg + TCC_PRE_ONE : presc_reg;
        end
    end

    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            control_register_a <= TCC_RST8;
            control_register_b <= TCC_RST8;
            async_clock_select <= 1'b0;
            timer_mask_register <= 3'h0;
        end else begin
            if (wr_ctrl_a) control_register_a <= wr_data_in;
            if (wr_ctrl_b) control_register_b <= wr_data_in;
            if (wr_async) async_clock_select <= wr_data_in[TCC_AS_BIT]; // RULE8
            if (wr_mask) timer_mask_register <= wr_data_in[2:0]; // RULE5
        end
    end

    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            timer_count_value <= TCC_RST8;
            dir_reg           <= TCC_DIR_UP;
            block_reg         <= 1'b0;
        end else begin
            // Direction is kept across a count write
            if (wr_count) begin
                timer_count_value <= wr_data_in; // RULE14 RULE13
            end else if (timer_clock_tick) begin
                timer_count_value <= count_next; // RULE11
                dir_reg           <= dir_next;
            end
            // Held until a tick consumes it, so a stopped timer still blocks
            if (wr_count) block_reg <= 1'b1; // RULE19
            else if (timer_clock_tick) block_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            compare_value_a <= TCC_RST8;
            compare_value_b <= TCC_RST8;
            cmp_buf_a_reg   <= TCC_RST8;
            cmp_buf_b_reg   <= TCC_RST8;
        end else begin
            if (wr_cmp_a) cmp_buf_a_reg <= wr_data_in;
            if (wr_cmp_b) cmp_buf_b_reg <= wr_data_in;
            if (wr_cmp_a && !mode_pwm) compare_value_a <= wr_data_in; // RULE4
            else if (buf_load) compare_value_a <= cmp_buf_a_reg;
            if (wr_cmp_b && !mode_pwm) compare_value_b <= wr_data_in;
            else if (buf_load) compare_value_b <= cmp_buf_b_reg;
        end
    end

    // Set beats a same-cycle clear
    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            timer_flag_register <= 3'h0;
        end else begin
            timer_flag_register <= (timer_flag_register & ~flag_clr) | flag_set; // RULE18
        end
    end

    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            rd_data_out   <= TCC_RST8;
            osc_pin_out   <= 1'b0;
            ovf_req_out   <= 1'b0;
            cmp_a_req_out <= 1'b0;
            cmp_b_req_out <= 1'b0;
            top_out       <= 1'b0;
            bottom_out    <= 1'b0;
        end else begin
            // Zero outside the answer cycle, so reads can share an or-bus
            rd_data_out   <= rd_en_in ? rd_mux : TCC_RST8;
            // Feedback for the crystal amplifier, off when not in async mode
            osc_pin_out   <= async_clock_select && !osc_sync_reg;
            ovf_req_out   <= req_next[TCC_OVF_BIT]; // RULE5
            cmp_a_req_out <= req_next[TCC_CMPA_BIT]; // RULE10
            cmp_b_req_out <= req_next[TCC_CMPB_BIT]; // RULE10
            top_out       <= at_max; // RULE17
            bottom_out    <= at_bottom; // RULE17 RULE1
        end
    end
endmodule : tcc_timer

// ### tb/tcc_timer_asserts.sv
// Purpose: Port checks for the 8-bit timer core
// Assumes: Shadows of mask, clock select and async select follow port writes
// Notes:   Bound from the testbench top file
`timescale 1ns/10ps
module tcc_timer_asserts
    import tcc_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              resetn_in,
    input  wire logic [TCC_AW-1:0] addr_in,
    input  wire logic [TCC_DW-1:0] wr_data_in,
    input  wire logic              wr_en_in,
    input  wire logic              rd_en_in,
    input  wire logic              osc_pin_in,
    input  wire logic [TCC_DW-1:0] rd_data_out,
    input  wire logic              osc_pin_out,
    input  wire logic              ovf_req_out,
    input  wire logic              cmp_a_req_out,
    input  wire logic              cmp_b_req_out,
    input  wire logic              top_out,
    input  wire logic              bottom_out
);
    logic [2:0] mask_reg;
    logic [2:0] cs_reg;
    logic       as_reg;
    logic [2:0] idle_reg;
    wire        cnt_wr = wr_en_in && addr_in == TCC_OFS_COUNT;
    wire        fm_wr  = wr_en_in && (addr_in == TCC_OFS_FLAG || addr_in == TCC_OFS_MASK);
    wire        idle_go = cs_reg == TCC_CS_STOP && !cnt_wr;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mask_reg <= 3'h0;
            cs_reg   <= 3'h0;
            as_reg   <= 1'b0;
            idle_reg <= 3'h0;
        end else begin
            if (wr_en_in && addr_in == TCC_OFS_MASK) mask_reg <= wr_data_in[2:0];
            if (wr_en_in && addr_in == TCC_OFS_CTRL_B) cs_reg <= wr_data_in[2:0];
            if (wr_en_in && addr_in == TCC_OFS_ASYNC) as_reg <= wr_data_in[TCC_AS_BIT];
            idle_reg <= !idle_go ? 3'h0 : (idle_reg == 3'h7 ? idle_reg : idle_reg + 3'h1);
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_flag_read;
        rd_en_in && addr_in == TCC_OFS_FLAG;
    endsequence
    a_read_idle_zero: assert property (!$past(rd_en_in) |-> rd_data_out == 8'h00)
        else $error("Read data not zero outside read answer");
    a_flag_reserved: assert property (s_flag_read |=> rd_data_out[7:3] == 5'h00)
        else $error("Flag register reserved bits not zero");
    a_ovf_masked: assert property ($past(!mask_reg[0]) |-> !ovf_req_out)
        else $error("Overflow request while masked");
    a_cmpa_masked: assert property ($past(!mask_reg[1]) |-> !cmp_a_req_out)
        else $error("Compare A request while masked");
    a_cmpb_masked: assert property ($past(!mask_reg[2]) |-> !cmp_b_req_out)
        else $error("Compare B request while masked");
    a_ovf_req_holds: assert property (ovf_req_out && !fm_wr && !$past(fm_wr) |=> ovf_req_out)
        else $error("Overflow request dropped without clear");
    a_cmpa_req_holds: assert property (cmp_a_req_out && !fm_wr && !$past(fm_wr) |=> cmp_a_req_out)
        else $error("Compare A request dropped without clear");
    a_stop_count_halts: assert property (idle_reg >= 3'h4 |-> $stable(top_out) && $stable(bottom_out))
        else $error("Count moved with clock stopped");
    a_top_bottom_excl: assert property (!(top_out && bottom_out))
        else $error("Top and bottom both raised");
    a_osc_out_off: assert property (!as_reg && !$past(as_reg) && !$past(as_reg, 2) |-> !osc_pin_out)
        else $error("Oscillator output active without async select");
endmodule : tcc_timer_asserts

// ### tb/tb_tcc_timer.sv
// Purpose: Self-checking bench for the 8-bit timer core
// Assumes: Register port with one-cycle read answer
// Notes:   Each register access takes two cycles, so strobes never abut
`timescale 1ns/10ps
module tb_tcc_timer
    import tcc_pkg::*;
;
    logic       clk_in = 1'b0;
    logic       resetn_in = 1'b0;
    logic [2:0] addr_in = 3'h0;
    logic [7:0] wr_data_in = 8'h00;
    logic       wr_en_in = 1'b0;
    logic       rd_en_in = 1'b0;
    logic       osc_pin_in = 1'b0;
    logic [7:0] rd_data_out;
    logic       osc_pin_out;
    logic       ovf_req_out;
    logic       cmp_a_req_out;
    logic       cmp_b_req_out;
    logic       top_out;
    logic       bottom_out;
    int         error_cnt = 0;
    int         check_count = 0;
    logic [7:0] v;
    logic [7:0] w;
    int         divs[7] = '{1, 8, 32, 64, 128, 256, 1024};
    tcc_timer i_tcc_timer (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .osc_pin_in(osc_pin_in), .rd_data_out(rd_data_out),
        .osc_pin_out(osc_pin_out), .ovf_req_out(ovf_req_out), .cmp_a_req_out(cmp_a_req_out),
        .cmp_b_req_out(cmp_b_req_out), .top_out(top_out), .bottom_out(bottom_out));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    task automatic wrap_up();
        if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
        @(posedge clk_in);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1 d = rd_data_out;
        @(posedge clk_in);
    endtask : rd
    task automatic t_reset_and_halt();
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), v);
            chk(v, 8'h00);
        end
        chk({7'h0, bottom_out}, 8'h01);
        wr(TCC_OFS_CMP_B, 8'hA5);
        rd(TCC_OFS_CMP_B, v);
        chk(v, 8'hA5);
        wr(TCC_OFS_COUNT, 8'h5A);
        repeat (20) @(posedge clk_in);
        rd(TCC_OFS_COUNT, v);
        chk(v, 8'h5A);
        wr(TCC_OFS_COUNT, 8'hFF);
        repeat (3) @(posedge clk_in);
        chk({6'h0, top_out, bottom_out}, 8'h02);
    endtask : t_reset_and_halt
    task automatic t_prescale();
        // Two reads 2*div apart always straddle exactly two ticks
        for (int i = 0; i < 7; i++) begin
            wr(TCC_OFS_CTRL_B, 8'(i + 1));
            rd(TCC_OFS_COUNT, v);
            repeat (2 * divs[i] - 2) @(posedge clk_in);
            rd(TCC_OFS_COUNT, w);
            chk(w - v, 8'h02);
        end
        // Tick on every clock, so the count write meets a tick
        wr(TCC_OFS_CTRL_B, 8'h01);
        wr(TCC_OFS_COUNT, 8'h80);
        rd(TCC_OFS_COUNT, v);
        chk(v, 8'h81);
        wr(TCC_OFS_CTRL_B, 8'h00);
    endtask : t_prescale
    task automatic t_flags();
        wr(TCC_OFS_FLAG, 8'h07);
        wr(TCC_OFS_CMP_A, 8'hF4);
        wr(TCC_OFS_CMP_B, 8'hF8);
        wr(TCC_OFS_COUNT, 8'hF0);
        wr(TCC_OFS_MASK, 8'h07);
        wr(TCC_OFS_CTRL_B, 8'h01);
        repeat (40) @(posedge clk_in);
        wr(TCC_OFS_CTRL_B, 8'h00);
        chk({5'h0, cmp_b_req_out, cmp_a_req_out, ovf_req_out}, 8'h07);
        rd(TCC_OFS_FLAG, v);
        chk(v, 8'h07);
        wr(TCC_OFS_MASK, 8'h01);
        repeat (3) @(posedge clk_in);
        chk({5'h0, cmp_b_req_out, cmp_a_req_out, ovf_req_out}, 8'h01);
        wr(TCC_OFS_FLAG, 8'h01);
        repeat (3) @(posedge clk_in);
        chk({7'h0, ovf_req_out}, 8'h00);
        rd(TCC_OFS_FLAG, v);
        chk(v, 8'h06);
        wr(TCC_OFS_FLAG, 8'h07);
    endtask : t_flags
    task automatic t_block_and_ctc();
        wr(TCC_OFS_COUNT, 8'h30);
        wr(TCC_OFS_CMP_A, 8'h30);
        wr(TCC_OFS_CTRL_B, 8'h07);
        repeat (1100) @(posedge clk_in);
        wr(TCC_OFS_CTRL_B, 8'h00);
        rd(TCC_OFS_FLAG, v);
        chk(v & 8'h02, 8'h00);
        wr(TCC_OFS_CTRL_A, 8'h02);
        wr(TCC_OFS_CMP_A, 8'h05);
        wr(TCC_OFS_COUNT, 8'h00);
        wr(TCC_OFS_CTRL_B, 8'h01);
        for (int i = 0; i < 12; i++) begin
            rd(TCC_OFS_COUNT, v);
            chk({7'h0, v > 8'h05}, 8'h00);
        end
        wr(TCC_OFS_CTRL_B, 8'h00);
        wr(TCC_OFS_CTRL_A, 8'h00);
    endtask : t_block_and_ctc
    task automatic t_async();
        wr(TCC_OFS_ASYNC, 8'h20);
        wr(TCC_OFS_COUNT, 8'h00);
        wr(TCC_OFS_CTRL_B, 8'h01);
        repeat (10) begin
            osc_pin_in <= 1'b1;
            repeat (8) @(posedge clk_in);
            osc_pin_in <= 1'b0;
            repeat (8) @(posedge clk_in);
        end
        chk({7'h0, osc_pin_out}, 8'h01);
        rd(TCC_OFS_COUNT, v);
        chk(v, 8'h0A);
        repeat (20) @(posedge clk_in);
        rd(TCC_OFS_COUNT, v);
        chk(v, 8'h0A);
        wr(TCC_OFS_CTRL_B, 8'h00);
        wr(TCC_OFS_ASYNC, 8'h00);
    endtask : t_async
    task automatic t_pwm();
        logic [7:0] pc_exp[5];
        pc_exp = '{8'h01, 8'h03, 8'h05, 8'h03, 8'h01};
        wr(TCC_OFS_FLAG, 8'h07);
        wr(TCC_OFS_CMP_A, 8'h05);
        wr(TCC_OFS_COUNT, 8'h00);
        wr(TCC_OFS_CTRL_A, 8'h01);
        wr(TCC_OFS_CTRL_B, 8'h09);
        for (int i = 0; i < 10; i++) begin
            rd(TCC_OFS_COUNT, v);
            chk(v, pc_exp[i % 5]);
        end
        wr(TCC_OFS_CTRL_B, 8'h00);
        rd(TCC_OFS_FLAG, v);
        chk(v & 8'h01, 8'h01);
        wr(TCC_OFS_FLAG, 8'h07);
        wr(TCC_OFS_COUNT, 8'h00);
        wr(TCC_OFS_CTRL_A, 8'h03);
        wr(TCC_OFS_CTRL_B, 8'h09);
        for (int i = 0; i < 6; i++) begin
            rd(TCC_OFS_COUNT, v);
            chk(v, 8'(2 * (i % 3) + 1));
        end
        wr(TCC_OFS_CTRL_B, 8'h00);
        rd(TCC_OFS_FLAG, v);
        chk(v & 8'h01, 8'h01);
        wr(TCC_OFS_CTRL_A, 8'h00);
        wr(TCC_OFS_FLAG, 8'h07);
    endtask : t_pwm
    initial begin
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        t_reset_and_halt();
        t_prescale();
        t_flags();
        t_block_and_ctc();
        t_async();
        t_pwm();
        wrap_up();
    end
    initial begin
        // Tests take about 5000 cycles
        repeat (20000) @(posedge clk_in);
        error_cnt++;
        wrap_up();
    end
endmodule : tb_tcc_timer
bind tcc_timer tcc_timer_asserts i_tcc_timer_asserts (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .osc_pin_in(osc_pin_in),
    .rd_data_out(rd_data_out), .osc_pin_out(osc_pin_out), .ovf_req_out(ovf_req_out),
    .cmp_a_req_out(cmp_a_req_out), .cmp_b_req_out(cmp_b_req_out), .top_out(top_out), .bottom_out(bottom_out));
